/* hw/cds_ctrl.sv */
/*
 * cds_ctrl: doze throttling, sleep and idle entry, wake-up sequencing and
 * AXI4-Lite register slave of the CPU power-saving controller.
 * Assumes the CPU core, interrupt logic and watchdog share aclk; reset
 * request pins are asynchronous and are synchronised here.
 */
// Operation
// - while slowdown enabled, run one instruction cycle per ratio period; code 100 gives 1:32.
// - ratio code 001 runs one cycle, then idles three.
// - oscillators and peripheral clock keep running while throttled.
// - entering an interrupt routine copies slowdown enable into resume bit.
// - routine runs full speed if recover set, else stays throttled.
// - on return, resume bit set keeps throttling, clear clears slowdown enable.
// - sleep instruction enters sleep when halt select clear, idle when set.
// - sleep entry clears watchdog; watchdog keeps running if configured so.
// - sleep entry clears powerdown flag and sets watchdog expiry flag.
// - sleep stops cpu and system clocks; slow, fast, secondary oscillators stay.
// - conversion continues on dedicated oscillator, abandoned on system clock.
// - pins hold their pre-sleep drive state during sleep.
// - sleep changes no reset source except the watchdog.
// - pin, brownout, power-on reset wake by reset; others continue execution.
// - sleep instruction prefetches the following instruction.
// - enabled interrupt wakes regardless of global enable.
// - after wake, run next instruction; with global enable, then vector 0004h.
// - watchdog cleared on every wake from sleep.
// - pending enabled interrupt with global enable clear makes sleep a no-op; the code still enters idle when halt select is set.
// - interrupt during or after sleep: sleep completes, wakes at once.
`timescale 1ns/1ps
`default_nettype none
module cds_ctrl
	import cds_pkg::*;
(
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite write address and data
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// cpu core events
	input  wire cds_cpu_evt_t         cpu_evt,
	input  wire logic                 global_irq_enable,
	input  wire logic                 irq_pending_enabled,
	// watchdog
	input  wire logic                 wdt_timeout,
	output logic                      wdt_clear,
	output logic                      wdt_run_in_sleep,
	// reset sources (asynchronous pins)
	input  wire logic                 external_reset_pin_n,
	input  wire logic                 brownout_reset,
	input  wire logic                 power_on_reset,
	output logic                      device_reset_req,
	// clocks
	output cds_clk_en_t               clk_en,
	// cpu sequencing
	output logic                      prefetch_next,
	output logic                      irq_vector_req,
	output logic [11:0]               irq_vector_addr,
	// peripherals
	output logic                      adc_abandon,
	output logic                      io_hold
);

	// ==========================================================
	// registers and state
	logic [7:0]              ctrl;
	logic                    powerdown_flag;
	logic                    watchdog_expiry_flag;
	logic [2:0]              cfg;
	cds_state_t              state;
	logic                    isr_full_speed;
	logic [7:0]              doze_cnt;
	logic [CDS_OST_W-1:0]    ost_cnt;
	logic [2:0]              rst_meta;
	logic [2:0]              rst_sync;

	// axi internals
	logic                    aw_got;
	logic                    w_got;
	logic [7:0]              aw_addr;
	logic [31:0]             w_data;
	logic [3:0]              w_strb;
	logic                    wr_fire;

	logic                    sleep_cmd;
	logic                    sleep_nop;
	logic                    throttle;
	logic                    wake_src;

	// ==========================================================
	// decode helpers
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
		addr_hit = (addr[7:2] == off[7:2]);
	endfunction

	function automatic logic addr_mapped(input logic [7:0] addr);
		addr_mapped = addr_hit(addr, CDS_OFF_CTRL) || addr_hit(addr, CDS_OFF_STATUS) ||
			addr_hit(addr, CDS_OFF_CFG) || addr_hit(addr, CDS_OFF_STATE);
	endfunction

	// period minus one: 2^(code+1) - 1
	function automatic logic [7:0] doze_last(input logic [CDS_RATIO_W-1:0] code);
		logic [8:0] p;
		p = 9'h001 << ({1'b0, code} + 4'h1);
		doze_last = 8'(p - 9'h001);
	endfunction

	assign wr_fire   = aw_got && w_got && !s_axi_bvalid;
	assign sleep_cmd = (state == CDS_ST_RUN) && cpu_evt.sleep_exec;
	// pending before the instruction with global enable clear
	assign sleep_nop = !global_irq_enable && irq_pending_enabled;
	assign throttle  = ctrl[CDS_CTRL_SLOW_EN] && !isr_full_speed;
	assign wake_src  = irq_pending_enabled || wdt_timeout;

	// ==========================================================
	// reset pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_meta <= 3'h0;
			rst_sync <= 3'h0;
		end else begin
			rst_meta <= {power_on_reset, brownout_reset, !external_reset_pin_n};
			rst_sync <= rst_meta;
		end
	end

	// pin resets act the same in every mode; watchdog only resets while running
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			device_reset_req <= 1'b0;
		end else begin
			device_reset_req <= (|rst_sync) || (wdt_timeout && state == CDS_ST_RUN);
		end
	end

	// ==========================================================
	// axi write channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got        <= 1'b0;
			aw_addr       <= 8'h00;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got        <= 1'b1;
			aw_addr       <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_got        <= 1'b0;
			s_axi_awready <= 1'b1;
		end else if (!aw_got) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got        <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got        <= 1'b1;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_got        <= 1'b0;
			s_axi_wready <= 1'b1;
		end else if (!w_got) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CDS_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_mapped(aw_addr) ? CDS_RESP_OKAY : CDS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// axi read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= CDS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= addr_mapped(s_axi_araddr) ? CDS_RESP_OKAY : CDS_RESP_SLVERR;
			if (addr_hit(s_axi_araddr, CDS_OFF_CTRL)) begin
				s_axi_rdata <= {24'h000000, ctrl};
			end else if (addr_hit(s_axi_araddr, CDS_OFF_STATUS)) begin
				s_axi_rdata <= {30'h0, watchdog_expiry_flag, powerdown_flag};
			end else if (addr_hit(s_axi_araddr, CDS_OFF_CFG)) begin
				s_axi_rdata <= {29'h0, cfg};
			end else if (addr_hit(s_axi_araddr, CDS_OFF_STATE)) begin
				s_axi_rdata <= {28'h0000000, isr_full_speed, state};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// power control register; hardware updates win over a same-cycle write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CDS_CTRL_RESET;
		end else begin
			if (wr_fire && w_strb[0] && addr_hit(aw_addr, CDS_OFF_CTRL)) begin
				ctrl <= {w_data[7:4], 1'b0, w_data[2:0]};
			end
			if (cpu_evt.isr_enter) begin
				ctrl[CDS_CTRL_RESUME] <= ctrl[CDS_CTRL_SLOW_EN];
			end
			if (cpu_evt.isr_return) begin
				ctrl[CDS_CTRL_SLOW_EN] <= ctrl[CDS_CTRL_RESUME];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= CDS_CFG_RESET;
		end else if (wr_fire && w_strb[0] && addr_hit(aw_addr, CDS_OFF_CFG)) begin
			cfg <= w_data[2:0];
		end
	end

	// full-speed service only when recover is set on entry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			isr_full_speed <= 1'b0;
		end else if (cpu_evt.isr_enter) begin
			isr_full_speed <= ctrl[CDS_CTRL_ROI] && ctrl[CDS_CTRL_SLOW_EN];
		end else if (cpu_evt.isr_return) begin
			isr_full_speed <= 1'b0;
		end
	end

	// ==========================================================
	// doze divider: cpu gets the cycle where the count is zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			doze_cnt <= 8'h00;
		end else if (state != CDS_ST_RUN || !throttle) begin
			doze_cnt <= 8'h00;
		end else if (doze_cnt >= doze_last(ctrl[CDS_CTRL_RATIO_LSB +: CDS_RATIO_W])) begin
			doze_cnt <= 8'h00;
		end else begin
			doze_cnt <= doze_cnt + 8'h01;
		end
	end

	// ==========================================================
	// power mode sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state   <= CDS_ST_RUN;
			ost_cnt <= '0;
		end else begin
			case (state)
				CDS_ST_RUN: begin
					if (sleep_cmd && ctrl[CDS_CTRL_HALT_SEL]) begin
						state <= CDS_ST_IDLE;
					end else if (sleep_cmd && !sleep_nop) begin
						state <= CDS_ST_SLEEP;
					end
				end
				CDS_ST_IDLE: begin
					// idle ends on any enabled interrupt or watchdog, no oscillator restart
					if (wake_src) begin
						state <= CDS_ST_WAKE_EXEC;
					end
				end
				CDS_ST_SLEEP: begin
					// a late interrupt is seen here one cycle after entry
					if (wake_src) begin
						ost_cnt <= CDS_OST_W'(CDS_OST_CYCLES - 1);
						state   <= cfg[CDS_CFG_CRYSTAL] ? CDS_ST_OST : CDS_ST_WAKE_EXEC;
					end
				end
				CDS_ST_OST: begin
					if (ost_cnt == '0) begin
						state <= CDS_ST_WAKE_EXEC;
					end else begin
						ost_cnt <= ost_cnt - 1'b1;
					end
				end
				CDS_ST_WAKE_EXEC: begin
					state <= CDS_ST_RUN;
				end
				default: begin
					state <= CDS_ST_RUN;
				end
			endcase
		end
	end

	// ==========================================================
	// status flags; untouched by the no-op sleep
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			powerdown_flag       <= CDS_PD_RESET;
			watchdog_expiry_flag <= CDS_TO_RESET;
		end else if (sleep_cmd && !ctrl[CDS_CTRL_HALT_SEL] && !sleep_nop) begin
			powerdown_flag       <= 1'b0;
			watchdog_expiry_flag <= 1'b1;
		end else if (wdt_timeout && state == CDS_ST_RUN) begin
			watchdog_expiry_flag <= 1'b0;
		end
	end

	// watchdog and prescaler clear on sleep entry and on wake from sleep, not on wake from idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdt_clear        <= 1'b0;
			wdt_run_in_sleep <= 1'b0;
		end else begin
			wdt_clear <= (sleep_cmd && !ctrl[CDS_CTRL_HALT_SEL] && !sleep_nop) ||
				(state == CDS_ST_SLEEP && wake_src);
			wdt_run_in_sleep <= cfg[CDS_CFG_WDT_SLEEP];
		end
	end

	// ==========================================================
	// clocks and cpu sequencing outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_en          <= '{cpu_clk_en: 1'b1, sys_clk_en: 1'b1, slow_internal_osc_en: 1'b1,
				fast_internal_osc_en: 1'b1, secondary_osc_en: 1'b1};
			prefetch_next   <= 1'b0;
			irq_vector_req  <= 1'b0;
			irq_vector_addr <= CDS_IRQ_VECTOR;
			adc_abandon     <= 1'b0;
			io_hold         <= 1'b0;
		end else begin
			case (state)
				CDS_ST_RUN:       clk_en.cpu_clk_en <= !throttle || doze_cnt == 8'h00;
				CDS_ST_WAKE_EXEC: clk_en.cpu_clk_en <= 1'b1;
				default:          clk_en.cpu_clk_en <= 1'b0;
			endcase
			// system clock keeps running in doze and idle, stops in sleep
			clk_en.sys_clk_en           <= state != CDS_ST_SLEEP && state != CDS_ST_OST;
			clk_en.slow_internal_osc_en <= 1'b1;
			clk_en.fast_internal_osc_en <= 1'b1;
			clk_en.secondary_osc_en     <= 1'b1;
			prefetch_next   <= sleep_cmd;
			irq_vector_req  <= state == CDS_ST_WAKE_EXEC && global_irq_enable && irq_pending_enabled;
			irq_vector_addr <= CDS_IRQ_VECTOR;
			adc_abandon     <= sleep_cmd && !ctrl[CDS_CTRL_HALT_SEL] && !sleep_nop &&
				!cfg[CDS_CFG_ADC_DEDIC];
			// async peripherals may still drive their own pins
			io_hold <= state == CDS_ST_SLEEP || state == CDS_ST_OST;
		end
	end

endmodule
`default_nettype wire

/* include/cds_pkg.sv */
/*
 * cds_pkg: register map, field positions, reset values, timing counts and
 * carrier types of the CPU doze and sleep controller.
 * Assumes one 100 MHz aclk domain and a 32-bit AXI4-Lite register bus.
 */
`default_nettype none
package cds_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] CDS_OFF_CTRL   = 8'h00;
	localparam logic [7:0] CDS_OFF_STATUS = 8'h04;
	localparam logic [7:0] CDS_OFF_CFG    = 8'h08;
	localparam logic [7:0] CDS_OFF_STATE  = 8'h0C;

	// ==========================================================
	// cpu_power_control_reg fields
	localparam int CDS_CTRL_HALT_SEL  = 7;
	localparam int CDS_CTRL_SLOW_EN   = 6;
	localparam int CDS_CTRL_ROI       = 5;
	localparam int CDS_CTRL_RESUME    = 4;
	localparam int CDS_CTRL_RATIO_LSB = 0;
	localparam int CDS_RATIO_W        = 3;
	localparam logic [7:0] CDS_CTRL_RESET = 8'h00;

	// status fields
	localparam int CDS_STAT_PD = 0;
	localparam int CDS_STAT_TO = 1;
	localparam logic CDS_PD_RESET = 1'b1;
	localparam logic CDS_TO_RESET = 1'b1;

	// configuration fields
	localparam int CDS_CFG_CRYSTAL    = 0;
	localparam int CDS_CFG_ADC_DEDIC  = 1;
	localparam int CDS_CFG_WDT_SLEEP  = 2;
	localparam logic [2:0] CDS_CFG_RESET = 3'h0;

	// ==========================================================
	// timing
	localparam int CDS_CLK_PERIOD_NS  = 10;
	localparam int CDS_OSC_PERIOD_NS  = 10;
	localparam int CDS_OST_OSC_PERIODS = 1024;
	localparam int CDS_OST_CYCLES =
		(CDS_OST_OSC_PERIODS * CDS_OSC_PERIOD_NS + CDS_CLK_PERIOD_NS - 1) / CDS_CLK_PERIOD_NS;
	localparam int CDS_OST_W = 11;
	localparam logic [11:0] CDS_IRQ_VECTOR = 12'h004;

	// AXI responses
	localparam logic [1:0] CDS_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CDS_RESP_SLVERR = 2'h2;

	// ==========================================================
	// carriers
	typedef enum logic [2:0] {
		CDS_ST_RUN,
		CDS_ST_IDLE,
		CDS_ST_SLEEP,
		CDS_ST_OST,
		CDS_ST_WAKE_EXEC
	} cds_state_t;

	typedef struct packed {
		logic sleep_exec;
		logic isr_enter;
		logic isr_return;
	} cds_cpu_evt_t;

	typedef struct packed {
		logic cpu_clk_en;
		logic sys_clk_en;
		logic slow_internal_osc_en;
		logic fast_internal_osc_en;
		logic secondary_osc_en;
	} cds_clk_en_t;

endpackage
`default_nettype wire

/* bench/cds_ctrl_props.sv */
/* cds_ctrl_props: port-level assertions for cds_ctrl, bound to every instance.
   Assumes the bench pulses wdt_timeout only while the block sleeps or runs, never during start-up. */
`timescale 1ns/1ps
`default_nettype none
module cds_ctrl_props
	import cds_pkg::*;
(
	// clock and reset
	input wire logic         aclk,
	input wire logic         aresetn,
	// core and sources
	input wire cds_cpu_evt_t cpu_evt,
	input wire logic         global_irq_enable,
	input wire logic         wdt_timeout,
	input wire logic         external_reset_pin_n,
	input wire logic         brownout_reset,
	input wire logic         power_on_reset,
	// watched outputs
	input wire logic         wdt_clear,
	input wire logic         device_reset_req,
	input wire cds_clk_en_t  clk_en,
	input wire logic         prefetch_next,
	input wire logic         irq_vector_req,
	input wire logic [11:0]  irq_vector_addr,
	input wire logic         adc_abandon,
	input wire logic         io_hold
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ====================
	// sequences
	sequence s_rst_hold;
		(brownout_reset || power_on_reset || !external_reset_pin_n) [*4];
	endsequence
	sequence s_sleep_wdt;
		io_hold && wdt_timeout;
	endsequence

	// ====================
	// properties
	property p_vec_addr;
		irq_vector_addr == CDS_IRQ_VECTOR;
	endproperty
	property p_osc_keep;
		clk_en.slow_internal_osc_en && clk_en.fast_internal_osc_en && clk_en.secondary_osc_en;
	endproperty
	// one cycle of slack either way between clock gating and pin hold
	property p_sys_clk;
		!clk_en.sys_clk_en |-> ##[0:1] (io_hold || $past(io_hold));
	endproperty
	property p_hold_cpu;
		io_hold [*3] |-> !$past(clk_en.cpu_clk_en);
	endproperty
	property p_prefetch;
		prefetch_next |-> $past(cpu_evt.sleep_exec);
	endproperty
	property p_sleep_entry;
		adc_abandon |-> wdt_clear && prefetch_next && $past(cpu_evt.sleep_exec);
	endproperty
	property p_vec_gie;
		irq_vector_req |-> $past(global_irq_enable) && !io_hold;
	endproperty
	property p_wake_wdt;
		s_sleep_wdt |-> ##[1:2] wdt_clear;
	endproperty
	property p_wdt_noreset;
		s_sleep_wdt |=> !device_reset_req [*2];
	endproperty
	property p_reset_src;
		s_rst_hold |-> ##[0:4] device_reset_req;
	endproperty

	a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");
	a_osc_keep: assert property (p_osc_keep) else $error("oscillator enable dropped");
	a_sys_clk: assert property (p_sys_clk) else $error("system clock off outside sleep");
	a_hold_cpu: assert property (p_hold_cpu) else $error("cpu clock runs in sleep");
	a_prefetch: assert property (p_prefetch) else $error("prefetch without sleep");
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry incomplete");
	a_vec_gie: assert property (p_vec_gie) else $error("vector with global enable clear");
	a_wake_wdt: assert property (p_wake_wdt) else $error("watchdog not cleared on wake");
	a_wdt_noreset: assert property (p_wdt_noreset) else $error("watchdog reset in sleep");
	a_reset_src: assert property (p_reset_src) else $error("reset source ignored");
endmodule

bind cds_ctrl cds_ctrl_props i_cds_ctrl_props (.aclk, .aresetn, .cpu_evt, .global_irq_enable, .wdt_timeout,
	.external_reset_pin_n, .brownout_reset, .power_on_reset, .wdt_clear, .device_reset_req, .clk_en,
	.prefetch_next, .irq_vector_req, .irq_vector_addr, .adc_abandon, .io_hold);
`default_nettype wire

/* bench/cds_cpu_model.sv */
/* cds_cpu_model: CPU core stand-in that issues sleep and interrupt events.
   Assumes the bench holds req until done and then drops it. */
`timescale 1ns/1ps
`default_nettype none
module cds_cpu_model
	import cds_pkg::*;
(
	// clock and reset
	input wire logic         aclk,
	input wire logic         aresetn,
	// requests and gating
	input wire cds_clk_en_t  clk_en,
	input wire cds_cpu_evt_t req,
	// core events
	output var cds_cpu_evt_t cpu_evt,
	output logic             done
);
	// events leave only on an instruction cycle the core is granted
	always_ff @(posedge aclk) begin
		cpu_evt <= '0;
		done    <= 1'h0;
		if (aresetn && req != '0 && !done && clk_en.cpu_clk_en) begin
			cpu_evt <= req;
			done    <= 1'h1;
		end
	end
endmodule
`default_nettype wire

/* bench/test_cds_ctrl.sv */
/* test_cds_ctrl: self-checking bench for cds_ctrl.
   Assumes cds_cpu_model as the core; the bench drives buses, sources and the watchdog. */
`timescale 1ns/1ps
`default_nettype none
module test_cds_ctrl
	import cds_pkg::*;
;
	logic         aclk = 1'h0, aresetn = 1'h0;
	logic [7:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]  s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]   s_axi_wstrb = 4'hF;
	logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	cds_cpu_evt_t cpu_evt, req = '0;
	logic         global_irq_enable = 1'h0, irq_pending_enabled = 1'h0, wdt_timeout = 1'h0;
	logic         external_reset_pin_n = 1'h1, brownout_reset = 1'h0, power_on_reset = 1'h0;
	logic         done, wdt_clear, wdt_run_in_sleep, device_reset_req, prefetch_next;
	logic         irq_vector_req, adc_abandon, io_hold;
	logic [11:0]  irq_vector_addr;
	cds_clk_en_t  clk_en;
	int           miscompares = 0, compares = 0, n_cpu = 0, n_clr = 0, n_adc = 0, n_vec = 0;
	int           c, a, v, k, code;

	always #5 aclk = ~aclk;

	// counted mid-cycle so snapshots taken at rising edges never race
	always @(negedge aclk) begin
		if (clk_en.cpu_clk_en === 1'h1) n_cpu++;
		if (wdt_clear === 1'h1) n_clr++;
		if (adc_abandon === 1'h1) n_adc++;
		if (irq_vector_req === 1'h1) n_vec++;
	end

	cds_ctrl i_cds_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .cpu_evt, .global_irq_enable, .irq_pending_enabled, .wdt_timeout, .wdt_clear,
		.wdt_run_in_sleep, .external_reset_pin_n, .brownout_reset, .power_on_reset, .device_reset_req,
		.clk_en, .prefetch_next, .irq_vector_req, .irq_vector_addr, .adc_abandon, .io_hold);
	cds_cpu_model i_cds_cpu_model (.aclk, .aresetn, .clk_en, .req, .cpu_evt, .done);

	// ====================
	// helpers
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		chk("bresp", 32'(er), 32'(s_axi_bresp));
		s_axi_bready <= 1'h0;
	endtask
	task automatic rdc(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er, input string n);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		chk(n, e, s_axi_rdata);
		chk("rresp", 32'(er), 32'(s_axi_rresp));
		s_axi_rready <= 1'h0;
	endtask
	task automatic evt(input cds_cpu_evt_t e);
		req <= e;
		do @(posedge aclk); while (done !== 1'h1);
		req <= '0;
	endtask
	task automatic meas(input int w, input int e, input string n);
		int n0;
		n0 = n_cpu;
		repeat (w) @(posedge aclk);
		chk(n, e, n_cpu - n0);
	endtask
	task automatic do_reset;
		aresetn <= 1'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
	endtask
	function automatic int doze_n(input int w, input int cd);
		return w >> (cd + 1);
	endfunction
	task automatic report_and_stop;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ====================
	// tests
	initial begin
		void'($urandom(32'h6951C6C0));
		do_reset;
		rdc(CDS_OFF_CTRL, 32'h0, CDS_RESP_OKAY, "ctrl");
		rdc(CDS_OFF_STATUS, 32'h3, CDS_RESP_OKAY, "status");
		rdc(CDS_OFF_CFG, 32'h0, CDS_RESP_OKAY, "cfg");
		rdc(8'h10, 32'h0, CDS_RESP_SLVERR, "unmapped");
		wr(8'h10, 32'hFF, CDS_RESP_SLVERR);
		wr(CDS_OFF_STATUS, 32'h0, CDS_RESP_OKAY);
		rdc(CDS_OFF_STATUS, 32'h3, CDS_RESP_OKAY, "status_ro");
		wr(CDS_OFF_CTRL, 32'h8F, CDS_RESP_OKAY);
		rdc(CDS_OFF_CTRL, 32'h87, CDS_RESP_OKAY, "ctrl_rw");
		s_axi_wstrb <= 4'h0;
		wr(CDS_OFF_CTRL, 32'h0, CDS_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rdc(CDS_OFF_CTRL, 32'h87, CDS_RESP_OKAY, "ctrl_nostrb");
		$display("test registers done");
		for (int i = 0; i < 9; i++) begin
			code = (i < 8) ? i : int'($urandom % 8);
			wr(CDS_OFF_CTRL, 32'h40 | code, CDS_RESP_OKAY);
			repeat (4) @(posedge aclk);
			meas(8 << code, doze_n(8 << code, code), "doze");
		end
		wr(CDS_OFF_CTRL, 32'h61, CDS_RESP_OKAY);
		evt(3'h2);
		rdc(CDS_OFF_CTRL, 32'h71, CDS_RESP_OKAY, "isr_copy");
		meas(8, 8, "isr_full");
		evt(3'h1);
		rdc(CDS_OFF_CTRL, 32'h71, CDS_RESP_OKAY, "ret_keep");
		meas(8, 2, "ret_doze");
		wr(CDS_OFF_CTRL, 32'h41, CDS_RESP_OKAY);
		evt(3'h2);
		meas(8, 2, "isr_doze");
		wr(CDS_OFF_CTRL, 32'h41, CDS_RESP_OKAY);
		evt(3'h1);
		rdc(CDS_OFF_CTRL, 32'h01, CDS_RESP_OKAY, "ret_clear");
		meas(8, 8, "ret_full");
		$display("test doze done");
		wr(CDS_OFF_CTRL, 32'h0, CDS_RESP_OKAY);
		c = n_clr;
		a = n_adc;
		evt(3'h4);
		rdc(CDS_OFF_STATE, 32'h2, CDS_RESP_OKAY, "sleep");
		rdc(CDS_OFF_STATUS, 32'h2, CDS_RESP_OKAY, "flags");
		chk("entry_clr", 1, n_clr - c);
		chk("abandon", 1, n_adc - a);
		wdt_timeout <= 1'h1;
		@(posedge aclk);
		wdt_timeout <= 1'h0;
		repeat (6) @(posedge aclk);
		rdc(CDS_OFF_STATE, 32'h0, CDS_RESP_OKAY, "woken");
		chk("wake_clr", 2, n_clr - c);
		chk("no_reset", 0, 32'(device_reset_req));
		wr(CDS_OFF_CTRL, 32'h80, CDS_RESP_OKAY);
		global_irq_enable <= 1'h1;
		v = n_vec;
		evt(3'h4);
		rdc(CDS_OFF_STATE, 32'h1, CDS_RESP_OKAY, "idle");
		irq_pending_enabled <= 1'h1;
		repeat (8) @(posedge aclk);
		chk("vector", 1, n_vec - v);
		irq_pending_enabled <= 1'h0;
		global_irq_enable <= 1'h0;
		rdc(CDS_OFF_STATE, 32'h0, CDS_RESP_OKAY, "idle_out");
		$display("test sleep done");
		do_reset;
		irq_pending_enabled <= 1'h1;
		c = n_clr;
		evt(3'h4);
		repeat (4) @(posedge aclk);
		rdc(CDS_OFF_STATE, 32'h0, CDS_RESP_OKAY, "nop");
		rdc(CDS_OFF_STATUS, 32'h3, CDS_RESP_OKAY, "nop_flags");
		chk("nop_clr", 0, n_clr - c);
		irq_pending_enabled <= 1'h0;
		@(posedge aclk);
		c = n_clr;
		v = n_vec;
		evt(3'h4);
		irq_pending_enabled <= 1'h1;
		repeat (6) @(posedge aclk);
		irq_pending_enabled <= 1'h0;
		rdc(CDS_OFF_STATE, 32'h0, CDS_RESP_OKAY, "late");
		rdc(CDS_OFF_STATUS, 32'h2, CDS_RESP_OKAY, "late_flags");
		chk("late_clr", 2, n_clr - c);
		chk("late_novec", 0, n_vec - v);
		$display("test early and late interrupt done");
		wr(CDS_OFF_CFG, 32'h7, CDS_RESP_OKAY);
		@(posedge aclk);
		chk("wdt_run", 1, 32'(wdt_run_in_sleep));
		a = n_adc;
		evt(3'h4);
		repeat (3) @(posedge aclk);
		chk("adc_kept", 0, n_adc - a);
		wdt_timeout <= 1'h1;
		@(posedge aclk);
		wdt_timeout <= 1'h0;
		k = 0;
		while (clk_en.cpu_clk_en !== 1'h1 && k < 2000) begin
			@(posedge aclk);
			k++;
		end
		chk("ost", 1, 32'(k >= CDS_OST_CYCLES && k <= CDS_OST_CYCLES + 6));
		$display("test start-up delay done");
		for (int s = 0; s < 3; s++) begin
			do_reset;
			evt(3'h4);
			external_reset_pin_n <= (s != 0);
			brownout_reset <= (s == 1);
			power_on_reset <= (s == 2);
			repeat (8) @(posedge aclk);
			chk("reset_req", 1, 32'(device_reset_req));
			external_reset_pin_n <= 1'h1;
			brownout_reset <= 1'h0;
			power_on_reset <= 1'h0;
			repeat (4) @(posedge aclk);
		end
		$display("test reset wake done");
		report_and_stop;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		report_and_stop;
	end
endmodule
`default_nettype wire
